// >>> rtl/chob_pkg.sv
// constants and types for the channel hardware output double buffer
// ------------------------------------------------------------------
// ------------------------------------------------------------------
package chob_pkg;

    localparam int ADDR_W = 8;
    localparam int CNT_W = 16;

    // register byte addresses
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] STATE_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] COUNT_OFS = 8'h10;
    localparam logic [ADDR_W-1:0] CBA_OFS = 8'h14;
    localparam logic [ADDR_W-1:0] LBA_OFS = 8'h18;
    localparam logic [ADDR_W-1:0] DATA_OFS = 8'h1c;

    // control bits
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_SEL_BIT = 1;

    // interrupt status bits
    localparam int IRQ_W = 4;
    localparam int EV_REQ_BIT = 0;
    localparam int EV_EXIT_BIT = 1;
    localparam int EV_UNDER_BIT = 2;
    localparam int EV_REFUSE_BIT = 3;

    localparam logic [7:0] STATUS_OK = 8'h00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

    // deskew and parity delay
    localparam int CLK_NS = 50;
    localparam int DESKEW_NS = 260;
    localparam int DESKEW_CYC_I = (DESKEW_NS + CLK_NS - 1) / CLK_NS;
    localparam int DESKEW_CYC = DESKEW_CYC_I < 1 ? 1 : DESKEW_CYC_I;
    localparam logic [3:0] DESKEW_CNT = 4'(DESKEW_CYC);

    typedef struct packed {
        // bus slave
        logic wr_pend;
        logic rd_pend;
        logic [ADDR_W-1:0] addr;
        logic [31:0] rdata;
        // control
        logic sel_srv_out;
        logic flag_a;
        logic flag_b;
        logic busy;
        logic io_exit;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] byte_counter;
        logic [CNT_W-1:0] cba;
        logic [CNT_W-1:0] last_byte_address;
        // data path
        logic [7:0] stage_one;
        logic [7:0] stage_two;
        logic one_full;
        logic two_full;
        logic strobe;
        logic req;
        logic [3:0] deskew;
        logic srv_out;
        logic underrun;
        // interrupts
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
    } chob_state_t;

endpackage

// >>> rtl/chob_top.sv
// hardware controlled output path with two stage byte buffer
`timescale 1ns/1ns
`default_nettype none
module chob_top
(
    input wire logic hclk, // bus clock
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic hready, // bus ready
    input wire logic [31:0] hwdata, // write data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    output logic [31:0] hrdata, // read data
    input wire logic [7:0] adapter_status, // status from selected adapter
    input wire logic dev_srv_in, // adapter service in
    output logic chan_srv_out, // channel service out
    output logic [7:0] bus_out, // outbound byte lines
    output logic bus_out_parity, // odd parity of bus_out
    output logic svc_req, // service request to processor
    output logic io_exit, // last byte stored
    output logic underrun_priority_request, // both stages emptied
    output logic irq // level interrupt
);

    localparam int IRQ_W_L = chob_pkg::IRQ_W;
    localparam int CW = chob_pkg::CNT_W;

    chob_pkg::chob_state_t s_r;
    chob_pkg::chob_state_t s_nxt;

    logic dev_srv_in_q;
    logic addr_take;
    logic wr_now;
    logic [31:0] wd;
    logic [IRQ_W_L-1:0] ev;
    logic load_one;
    logic srv_fall;
    logic [chob_pkg::CNT_W-1:0] cba_inc;
    logic [chob_pkg::CNT_W-1:0] lba_inc;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    assign addr_take = hsel && hready &&
        (htrans == chob_pkg::HTRANS_NONSEQ) && (hsize == 3'h2);
    assign wr_now = s_r.wr_pend;
    assign wd = hwdata;

    always_comb
    begin
        rd_mux = 32'h0;
        case (s_r.addr)
            chob_pkg::CTRL_OFS:
                rd_mux[chob_pkg::CTRL_SEL_BIT] = s_r.sel_srv_out;
            chob_pkg::STATE_OFS:
                rd_mux = {14'h0, s_r.underrun, s_r.srv_out, s_r.req,
                    s_r.two_full, s_r.one_full, s_r.io_exit, s_r.busy,
                    s_r.flag_b, s_r.flag_a, dev_srv_in_q, s_r.stage_two};
            chob_pkg::IRQ_STAT_OFS:
                rd_mux[IRQ_W_L-1:0] = s_r.irq_stat;
            chob_pkg::IRQ_MASK_OFS:
                rd_mux[IRQ_W_L-1:0] = s_r.irq_mask;
            chob_pkg::COUNT_OFS:
                rd_mux[CW-1:0] = s_r.byte_counter;
            chob_pkg::CBA_OFS:
                rd_mux[CW-1:0] = s_r.cba;
            chob_pkg::LBA_OFS:
                rd_mux[CW-1:0] = s_r.last_byte_address;
            default:
                rd_mux = 32'h0;
        endcase
    end

    assign dev_srv_in_q = dev_srv_in;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    assign cba_inc = s_r.cba + {{(CW-1){1'b0}}, 1'b1};
    assign lba_inc = s_r.last_byte_address + {{(CW-1){1'b0}}, 1'b1};
    assign load_one = wr_now && (s_r.addr == chob_pkg::DATA_OFS)
        && s_r.flag_a;
    assign srv_fall = s_r.srv_out && !dev_srv_in;

    always_comb
    begin
        s_nxt = s_r;
        ev = '0;

        // bus phases: reads wait one cycle so a write just before lands
        s_nxt.wr_pend = addr_take && hwrite;
        s_nxt.rd_pend = addr_take && !hwrite;
        if (addr_take)
        begin
            s_nxt.addr = haddr[chob_pkg::ADDR_W-1:0];
        end
        else
        begin
            s_nxt.addr = s_r.addr;
        end
        if (s_r.rd_pend)
        begin
            s_nxt.rdata = rd_mux;
            s_nxt.addr = addr_take ? haddr[chob_pkg::ADDR_W-1:0] : s_r.addr;
        end

        // one cycle strobe, request on its trailing edge
        s_nxt.strobe = 1'b0;
        if (s_r.strobe)
        begin
            s_nxt.req = 1'b1;
            ev[chob_pkg::EV_REQ_BIT] = 1'b1;
        end

        // deskew timer runs once stage two is loaded
        if (s_r.two_full && s_r.deskew != 4'h0)
        begin
            s_nxt.deskew = s_r.deskew - 4'h1;
        end

        // register writes
        if (wr_now)
        begin
            case (s_r.addr)
                chob_pkg::CTRL_OFS:
                begin
                    s_nxt.sel_srv_out = wd[chob_pkg::CTRL_SEL_BIT];
                    if (wd[chob_pkg::CTRL_START_BIT])
                    begin
                        if (adapter_status == chob_pkg::STATUS_OK)
                        begin
                            s_nxt.flag_a = 1'b1;
                            s_nxt.flag_b = 1'b0;
                            s_nxt.byte_counter = s_r.count
                                - {{(CW-1){1'b0}}, 1'b1};
                            s_nxt.busy = 1'b1;
                            s_nxt.io_exit = 1'b0;
                            s_nxt.underrun = 1'b0;
                            s_nxt.sel_srv_out = 1'b0;
                        end
                        else
                        begin
                            ev[chob_pkg::EV_REFUSE_BIT] = 1'b1;
                        end
                    end
                end
                chob_pkg::IRQ_MASK_OFS:
                    s_nxt.irq_mask = wd[IRQ_W_L-1:0];
                chob_pkg::COUNT_OFS:
                    s_nxt.count = wd[CW-1:0];
                chob_pkg::CBA_OFS:
                    s_nxt.cba = wd[CW-1:0];
                chob_pkg::LBA_OFS:
                    s_nxt.last_byte_address = wd[CW-1:0];
                default:
                begin
                end
            endcase
        end

        // one store pass: byte into stage one, address bump and compare
        if (load_one)
        begin
            s_nxt.stage_one = wd[7:0];
            s_nxt.one_full = 1'b1;
            s_nxt.req = 1'b0;
            s_nxt.cba = cba_inc;
            if (cba_inc == lba_inc)
            begin
                s_nxt.io_exit = 1'b1;
                s_nxt.busy = 1'b1;
                ev[chob_pkg::EV_EXIT_BIT] = 1'b1;
            end
            else
            begin
                s_nxt.busy = 1'b0;
            end
        end
        else if (s_r.one_full && !s_r.two_full && !s_r.strobe)
        begin
            // transfer blocked while stage two still full
            s_nxt.strobe = 1'b1;
            s_nxt.stage_two = s_r.stage_one;
            s_nxt.two_full = 1'b1;
            s_nxt.one_full = 1'b0;
            s_nxt.deskew = chob_pkg::DESKEW_CNT;
        end

        // service out interlock; withheld without a byte
        if (srv_fall)
        begin
            s_nxt.srv_out = 1'b0;
            s_nxt.byte_counter = s_r.byte_counter
                + {{(CW-1){1'b0}}, 1'b1};
            s_nxt.two_full = 1'b0;
            if (!s_r.one_full && !load_one)
            begin
                s_nxt.underrun = 1'b1;
                ev[chob_pkg::EV_UNDER_BIT] = 1'b1;
            end
        end
        else if (dev_srv_in && s_r.flag_a && s_r.two_full
            && s_r.deskew == 4'h0 && !s_r.sel_srv_out)
        begin
            s_nxt.srv_out = 1'b1;
        end
        if (s_r.two_full || s_r.one_full || load_one)
        begin
            s_nxt.underrun = s_nxt.underrun && !load_one;
        end

        // sticky status: a new event wins over a write-one clear
        if (wr_now && s_r.addr == chob_pkg::IRQ_STAT_OFS)
        begin
            s_nxt.irq_stat = (s_r.irq_stat & ~wd[IRQ_W_L-1:0]) | ev;
        end
        else
        begin
            s_nxt.irq_stat = s_r.irq_stat | ev;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign hreadyout = !s_r.rd_pend;
    assign hresp = 1'b0;
    assign hrdata = s_r.rdata;
    assign chan_srv_out = s_r.srv_out || s_r.sel_srv_out;
    assign bus_out = s_r.stage_two;
    assign bus_out_parity = ~^s_r.stage_two;
    assign svc_req = s_r.req;
    assign io_exit = s_r.io_exit;
    assign underrun_priority_request = s_r.underrun;
    assign irq = |(s_r.irq_stat & s_r.irq_mask);

endmodule // chob_top
`default_nettype wire

// >>> test/chob_top_sva.sv
// port checker for the output double buffer
`timescale 1ns/1ns
`default_nettype none
module chob_top_sva
(
    input wire logic hclk, // clock
    input wire logic hresetn, // reset, active low
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic [2:0] hsize, // size
    input wire logic hready, // bus ready
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic dev_srv_in, // service in
    input wire logic chan_srv_out, // service out
    input wire logic [7:0] bus_out, // byte lines
    input wire logic bus_out_parity, // parity
    input wire logic svc_req, // request
    input wire logic underrun_priority_request // underrun
);
    // ----
    // helpers
    // ----
    logic [7:0] prev_r;
    logic [3:0] stab_r;
    wire logic take = hsel && hready && htrans == chob_pkg::HTRANS_NONSEQ
        && hsize == 3'h2;
    wire logic rd_take = take && !hwrite;
    wire logic data_wr = take && hwrite && haddr[7:0] == chob_pkg::DATA_OFS;
    // same-byte reloads hide from this counter, so the bound is a floor
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            prev_r <= 8'h00;
            stab_r <= 4'h0;
        end
        else
        begin
            prev_r <= bus_out;
            stab_r <= (bus_out != prev_r) ? 4'h0
                : stab_r + {3'h0, stab_r != 4'hf};
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ----
    // properties
    // ----
    a_rise_needs_in:
        assert property ($rose(chan_srv_out) |-> $past(dev_srv_in))
        else $error("service out rose without service in");
    a_out_drops:
        assert property (chan_srv_out && !dev_srv_in |=> !chan_srv_out)
        else $error("service out kept after service in fell");
    a_out_holds:
        assert property (chan_srv_out && dev_srv_in |=> chan_srv_out)
        else $error("service out dropped early");
    a_deskew_wait:
        assert property ($rose(chan_srv_out) |-> stab_r >= 4'h4)
        else $error("service out before deskew delay");
    a_parity_odd:
        assert property (bus_out_parity == ~^bus_out)
        else $error("bad parity on byte lines");
    a_req_cleared:
        assert property (data_wr && svc_req |-> ##2 !svc_req)
        else $error("request kept after byte store");
    a_underrun_take:
        assert property ($rose(underrun_priority_request)
            |-> $fell(chan_srv_out))
        else $error("underrun without byte taken");
    a_read_wait:
        assert property (rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_resp_okay:
        assert property (!hresp)
        else $error("response not okay");
endmodule // chob_top_sva
`default_nettype wire

// >>> test/chob_adapter.sv
// adapter model on the far side of the service interlock
`timescale 1ns/1ns
`default_nettype none
module chob_adapter
(
    input wire logic clk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic ready_en, // model wants bytes
    input wire logic chan_srv_out, // service out
    input wire logic [7:0] bus_out, // byte lines
    output logic dev_srv_in, // service in
    output logic [7:0] got_byte, // last byte taken
    output logic [3:0] got_cnt // bytes taken
);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dev_srv_in <= 1'b0;
            got_byte <= 8'h00;
            got_cnt <= 4'h0;
        end
        // buffered model: it waits on a withheld byte
        else if (!dev_srv_in && !chan_srv_out && ready_en)
            dev_srv_in <= 1'b1;
        else if (dev_srv_in && chan_srv_out)
        begin
            got_byte <= bus_out;
            got_cnt <= got_cnt + 4'h1;
            dev_srv_in <= 1'b0;
        end
    end
endmodule // chob_adapter
`default_nettype wire

// >>> test/tb.sv
// testbench for the output double buffer
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [7:0] adapter_status = 8'h00;
    logic ready_en = 1'b0;
    logic rdy_n;
    logic [31:0] rdat_n;
    logic [31:0] rd;
    wire logic hreadyout, hresp, dev_srv_in, chan_srv_out, bus_out_parity;
    wire logic svc_req, io_exit, underrun_priority_request, irq;
    wire logic [31:0] hrdata;
    wire logic [7:0] bus_out, got_byte;
    wire logic [3:0] got_cnt;
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #25 hclk = ~hclk;
    // outputs only move on rising edges, so the low phase is race free
    always @(negedge hclk)
    begin
        rdy_n = hreadyout;
        rdat_n = hrdata;
    end
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            num_errors++;
            stop_test();
        end
    end
    chob_top u_chob_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .adapter_status(adapter_status),
        .dev_srv_in(dev_srv_in), .chan_srv_out(chan_srv_out),
        .bus_out(bus_out), .bus_out_parity(bus_out_parity),
        .svc_req(svc_req), .io_exit(io_exit), .irq(irq),
        .underrun_priority_request(underrun_priority_request));
    chob_adapter u_chob_adapter (.clk(hclk), .rst_n(hresetn),
        .ready_en(ready_en), .chan_srv_out(chan_srv_out), .bus_out(bus_out),
        .dev_srv_in(dev_srv_in), .got_byte(got_byte), .got_cnt(got_cnt));
    // ----
    // shared tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= chob_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge hclk);
        while (rdy_n !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (rdy_n !== 1'b1) @(posedge hclk);
        rd = rdat_n;
    endtask
    task automatic stop_test;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_refuse;
        adapter_status <= 8'h01;
        bus(1'b1, chob_pkg::COUNT_OFS, 32'h4);
        bus(1'b1, chob_pkg::CTRL_OFS, 32'h1);
        bus(1'b0, chob_pkg::STATE_OFS, 32'h0);
        chk(rd & 32'h200, 32'h0);
        bus(1'b0, chob_pkg::IRQ_STAT_OFS, 32'h0);
        chk(rd & 32'h8, 32'h8);
        bus(1'b1, chob_pkg::IRQ_STAT_OFS, 32'hf);
        adapter_status <= 8'h00;
    endtask
    task automatic t_start;
        bus(1'b1, chob_pkg::CBA_OFS, 32'h0);
        bus(1'b1, chob_pkg::LBA_OFS, 32'h2);
        bus(1'b1, chob_pkg::IRQ_MASK_OFS, 32'h4);
        bus(1'b1, chob_pkg::CTRL_OFS, 32'h1);
        bus(1'b0, chob_pkg::STATE_OFS, 32'h0);
        chk(rd & 32'he00, 32'ha00);
        bus(1'b0, chob_pkg::COUNT_OFS, 32'h0);
        chk(rd, 32'h3);
    endtask
    task automatic t_stream;
        bus(1'b1, chob_pkg::DATA_OFS, 32'ha5);
        wait (svc_req === 1'b1);
        @(negedge hclk);
        chk({24'h0, bus_out}, 32'ha5);
        bus(1'b0, chob_pkg::STATE_OFS, 32'h0);
        chk(rd & 32'h800, 32'h0);
        bus(1'b1, chob_pkg::DATA_OFS, 32'h3c);
        @(negedge hclk);
        chk({31'h0, svc_req}, 32'h0);
        bus(1'b0, chob_pkg::STATE_OFS, 32'h0);
        chk(rd & 32'h60ff, 32'h60a5);
        ready_en <= 1'b1;
        wait (got_cnt == 4'h2);
        @(negedge hclk);
        chk({24'h0, got_byte}, 32'h3c);
        wait (underrun_priority_request === 1'b1);
        @(negedge hclk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, chob_pkg::IRQ_STAT_OFS, 32'h4);
        @(negedge hclk);
        chk({31'h0, irq}, 32'h0);
        repeat (20) @(posedge hclk);
        chk({30'h0, dev_srv_in, chan_srv_out}, 32'h2);
        bus(1'b1, chob_pkg::DATA_OFS, 32'h96);
        wait (got_cnt == 4'h3);
        @(negedge hclk);
        chk({23'h0, io_exit, got_byte}, 32'h196);
        bus(1'b0, chob_pkg::STATE_OFS, 32'h0);
        chk(rd & 32'h800, 32'h800);
        bus(1'b0, chob_pkg::COUNT_OFS, 32'h0);
        chk(rd, 32'h6);
    endtask
    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_refuse();
        t_start();
        t_stream();
        stop_test();
    end
endmodule // tb
bind chob_top chob_top_sva u_chob_top_sva (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .dev_srv_in(dev_srv_in), .chan_srv_out(chan_srv_out),
    .bus_out(bus_out), .bus_out_parity(bus_out_parity), .svc_req(svc_req),
    .underrun_priority_request(underrun_priority_request));
`default_nettype wire
